// *** hdl/cpu_program_flow_core.sv ***
// Overview of operation
// RL1: Interrupt entry copies the core registers into shadow copies and return restores them, using no stack entry.
// RL2: The return stack is a dedicated sixteen-entry memory, each entry holding a 15-bit address.
// RL3: Pushing onto a full stack sets the overflow flag and popping an empty one sets the underflow flag in the power control register.
// RL4: With the stack error reset option enabled, either stack error also requests a software-type device reset.
// RL5: Two independent 16-bit pointers reach file registers, program memory and data EEPROM in one address space.
// RL6: An access through the indirect data port while its pointer targets program memory takes one extra instruction cycle.
// RL7: General purpose RAM is also reachable through a linear view so a pointer can walk past 80 bytes without bank breaks.
// RL8: The program counter is 15 bits wide over a 32K-word space of 14-bit words.
// RL9: Reset starts execution at 0000h and an accepted interrupt continues at 0004h; a step that reads program memory indirectly goes to the next address.
//      The code lets the indirect program read win, so an interrupt taken in that same step continues at the next address.
// RL10: Implemented flash ends at 1FFFh on 8k-word variants and 3FFFh on 16k-word variants.
// RL11: The instruction decoder accepts 48 distinct instruction codes.
// RL12: A call or an accepted interrupt pushes the next address and a return pops it into the program counter.
//       A return in a step with an indirect program read still pops, but the code loads the next address instead.
// RL13: Stack error flags stay set until software clears them and survive the reset they cause.
`timescale 1ns/100ps
`default_nettype none
module cpu_program_flow_core
   import flow_pkg::*;
#(
   parameter bit FLASH_16K = 1'b1
) (
   // Clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // Sequencing from the instruction decoder
   input  wire logic              step_i,
   input  wire logic [OPC_W-1:0]  opcode_i,
   input  wire logic              call_i,
   input  wire logic              ret_i,
   input  wire logic              retfie_i,
   input  wire logic              jump_i,
   input  wire logic [PC_W-1:0]   jump_addr_i,
   input  wire logic              irq_i,
   // Core registers to shadow
   input  wire logic [SHADOW_W-1:0] status_i,
   input  wire logic [SHADOW_W-1:0] wreg_i,
   input  wire logic [SHADOW_W-1:0] bsr_i,
   input  wire logic [SHADOW_W-1:0] pclath_i,
   // Pointers
   input  wire logic              ptr_sel_i,
   input  wire logic              ptr_wr_i,
   input  wire logic [PTR_W-1:0]  ptr_wdata_i,
   input  wire logic              ptr_inc_i,
   input  wire logic              indirect_access_i,
   // Power control register
   input  wire logic              stack_err_rst_en_i,
   input  wire logic              clr_overflow_i,
   input  wire logic              clr_underflow_i,
   output logic                   stack_overflow_flag_o,
   output logic                   stack_underflow_flag_o,
   output logic                   soft_reset_o,
   // Program memory bus
   output logic      [PC_W-1:0]   prog_addr_o,
   input  wire logic [INSN_W-1:0] prog_data_i,
   output logic                   prog_oob_o,
   // Data access through the indirect port
   output logic      [14:0]       data_addr_o,
   output target_e                data_target_o,
   output logic      [DATA_W-1:0] indirect_prog_data_o,
   output logic                   stall_o,
   output logic                   insn_illegal_o,
   // Shadow restore
   output logic                   restore_o,
   output logic [SHADOW_W-1:0]    status_shad_o,
   output logic [SHADOW_W-1:0]    wreg_shad_o,
   output logic [SHADOW_W-1:0]    bsr_shad_o,
   output logic [SHADOW_W-1:0]    pclath_shad_o
);
   localparam logic [PC_W-1:0] LAST_ADDR =
      FLASH_16K ? LAST_ADDR_16K : LAST_ADDR_8K;

   function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] pc);
      next_pc = pc + 1'b1;
   endfunction

   flow_state_e       state_q, state_d;
   logic [PC_W-1:0]   pc_q, pc_d;
   logic [PTR_W-1:0]  ptr0_q, ptr0_d, ptr1_q, ptr1_d;
   logic              ovf_q, ovf_d, unf_q, unf_d;
   logic              srst_q, srst_d;
   logic [SHADOW_W-1:0] sh_st_q, sh_st_d, sh_w_q, sh_w_d;
   logic [SHADOW_W-1:0] sh_b_q, sh_b_d, sh_p_q, sh_p_d;
   logic [INSN_W-1:0] fetch_q, fetch_d;
   logic              restore_q, restore_d;
   logic [14:0]       addr_q, addr_d;
   target_e           tgt_q, tgt_d;

   logic              run;
   logic              take_irq;
   logic              push, pop;
   logic [PC_W-1:0]   stack_top;
   logic              stk_ovf, stk_unf;
   logic [PTR_W-1:0]  cur_ptr;
   target_e           map_tgt;
   logic [14:0]       map_addr;

   assign run      = (state_q == ST_RUN) && step_i;
   assign take_irq = run && irq_i;
   assign push     = take_irq || (run && call_i); // RL12
   assign pop      = run && !irq_i && (ret_i || retfie_i); // RL12
   assign cur_ptr  = ptr_sel_i ? ptr1_q : ptr0_q;

   return_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PC_W)
   ) u_stack (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .push_i     (push),
      .pop_i      (pop),
      .push_addr_i(next_pc(pc_q)),
      .top_o      (stack_top),
      .overflow_o (stk_ovf),
      .underflow_o(stk_unf)
   );

   pointer_map u_map (
      .ptr_i   (cur_ptr),
      .target_o(map_tgt),
      .addr_o  (map_addr)
   );

   // Flow state and program counter
   always_comb begin
      state_d = state_q;
      pc_d    = pc_q;
      fetch_d = fetch_q;
      srst_d  = 1'b0;
      unique case (state_q)
         ST_RUN: begin
            if (run) begin
               if (indirect_access_i && map_tgt == TGT_PROG) begin
                  state_d = ST_FETCH; // RL6
               end else if (take_irq) begin
                  pc_d = IRQ_VECTOR; // RL9
               end else if (pop) begin
                  pc_d = stack_top; // RL12
               end else if (jump_i || call_i) begin
                  pc_d = jump_addr_i;
               end else begin
                  pc_d = next_pc(pc_q); // RL8
               end
            end
            if ((stk_ovf || stk_unf) && stack_err_rst_en_i) begin
               state_d = ST_RST; // RL4
            end
         end
         ST_FETCH: begin
            fetch_d = prog_data_i; // RL6
            pc_d    = next_pc(pc_q);
            state_d = ST_RUN;
         end
         ST_RST: begin
            srst_d  = 1'b1; // RL4
            pc_d    = RESET_VECTOR;
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_q <= ST_RUN;
         pc_q    <= RESET_VECTOR; // RL9
         fetch_q <= '0;
         srst_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         pc_q    <= pc_d;
         fetch_q <= fetch_d;
         srst_q  <= srst_d;
      end
   end

   // Pointers
   always_comb begin
      ptr0_d = ptr0_q;
      ptr1_d = ptr1_q;
      if (ptr_wr_i) begin
         if (ptr_sel_i) ptr1_d = ptr_wdata_i; // RL5
         else           ptr0_d = ptr_wdata_i;
      end else if (ptr_inc_i && state_q == ST_RUN) begin
         if (ptr_sel_i) ptr1_d = ptr1_q + 1'b1; // RL7
         else           ptr0_d = ptr0_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ptr0_q <= '0;
         ptr1_q <= '0;
      end else begin
         ptr0_q <= ptr0_d;
         ptr1_q <= ptr1_d;
      end
   end

   // Stack error flags; a new error beats a clear in the same cycle.
   // They are kept out of rst_i on purpose so the cause outlives the reset.
   always_comb begin
      ovf_d = ovf_q;
      unf_d = unf_q;
      if (clr_overflow_i)  ovf_d = 1'b0;
      if (clr_underflow_i) unf_d = 1'b0;
      if (stk_ovf) ovf_d = 1'b1; // RL3
      if (stk_unf) unf_d = 1'b1; // RL3
   end

   // Power-up value stands for the power-on clear; no reset reaches it
   logic flags_init_q = 1'b0;
   always_ff @(posedge clk_sys_i) begin
      flags_init_q <= 1'b1;
      if (!flags_init_q) begin
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
      end else begin
         ovf_q <= ovf_d; // RL13
         unf_q <= unf_d; // RL13
      end
   end

   // Shadow registers
   always_comb begin
      sh_st_d   = sh_st_q;
      sh_w_d    = sh_w_q;
      sh_b_d    = sh_b_q;
      sh_p_d    = sh_p_q;
      restore_d = 1'b0;
      if (take_irq) begin
         sh_st_d = status_i; // RL1
         sh_w_d  = wreg_i;
         sh_b_d  = bsr_i;
         sh_p_d  = pclath_i;
      end else if (run && retfie_i) begin
         restore_d = 1'b1; // RL1
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sh_st_q   <= '0;
         sh_w_q    <= '0;
         sh_b_q    <= '0;
         sh_p_q    <= '0;
         restore_q <= 1'b0;
      end else begin
         sh_st_q   <= sh_st_d;
         sh_w_q    <= sh_w_d;
         sh_b_q    <= sh_b_d;
         sh_p_q    <= sh_p_d;
         restore_q <= restore_d;
      end
   end

   // Registered data address
   always_comb begin
      addr_d = map_addr;
      tgt_d  = map_tgt;
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         addr_q <= '0;
         tgt_q  <= TGT_FILE;
      end else begin
         addr_q <= addr_d;
         tgt_q  <= tgt_d;
      end
   end

   // Program fetch address; a pointer read borrows the bus for one cycle
   // Latched address, so a post-increment in the same step is not seen
   assign prog_addr_o = (state_q == ST_FETCH) ? addr_q : pc_q;
   assign prog_oob_o  = prog_addr_o > LAST_ADDR; // RL10
   assign stall_o     = (state_q != ST_RUN); // RL6
   assign insn_illegal_o = opcode_i >= OPC_W'(NUM_INSNS); // RL11

   assign data_addr_o            = addr_q;
   assign data_target_o          = tgt_q;
   assign indirect_prog_data_o   = fetch_q[DATA_W-1:0];
   assign stack_overflow_flag_o  = ovf_q;
   assign stack_underflow_flag_o = unf_q;
   assign soft_reset_o           = srst_q;
   assign restore_o              = restore_q;
   assign status_shad_o          = sh_st_q;
   assign wreg_shad_o            = sh_w_q;
   assign bsr_shad_o             = sh_b_q;
   assign pclath_shad_o          = sh_p_q;
endmodule
`default_nettype wire

// *** hdl/flow_pkg.sv ***
package flow_pkg;
   localparam int unsigned PC_W         = 15;
   localparam int unsigned STACK_DEPTH  = 16;
   localparam int unsigned PTR_W        = 16;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned INSN_W       = 14;
   localparam int unsigned OPC_W        = 6;
   localparam int unsigned NUM_INSNS    = 48;
   localparam logic [14:0] RESET_VECTOR = 15'h0000;
   localparam logic [14:0] IRQ_VECTOR   = 15'h0004;
   localparam logic [14:0] LAST_ADDR_8K  = 15'h1FFF;
   localparam logic [14:0] LAST_ADDR_16K = 15'h3FFF;
   // Unified pointer space: bit 15 selects program memory
   localparam logic [15:0] PTR_PROG_BASE = 16'h8000;
   // Linear view of general purpose RAM
   localparam logic [15:0] PTR_LIN_BASE  = 16'h2000;
   localparam logic [15:0] PTR_LIN_TOP   = 16'h29AF;
   localparam logic [6:0]  BANK_RAM_BASE = 7'h20;
   localparam logic [6:0]  BANK_RAM_SIZE = 7'h50;
   // Data EEPROM window within the unified space
   localparam logic [15:0] PTR_EE_BASE   = 16'h7000;
   localparam logic [15:0] PTR_EE_TOP    = 16'h70FF;
   localparam int unsigned SHADOW_W     = 8;
   typedef enum logic [1:0] {
      TGT_FILE = 2'h0,
      TGT_PROG = 2'h1,
      TGT_EE   = 2'h2
   } target_e;
   typedef enum logic [1:0] {
      ST_RUN   = 2'h0,
      ST_FETCH = 2'h1,
      ST_RST   = 2'h3
   } flow_state_e;
endpackage

// *** hdl/pointer_map.sv ***
`timescale 1ns/100ps
`default_nettype none
module pointer_map
   import flow_pkg::*;
(
   // Pointer value
   input  wire logic [PTR_W-1:0] ptr_i,
   // Decoded target
   output target_e               target_o,
   output logic      [14:0]      addr_o
);
   logic [15:0] lin_off;
   logic [15:0] bank;
   logic [15:0] off;

   always_comb begin
      lin_off  = ptr_i - PTR_LIN_BASE;
      bank     = lin_off / 16'(BANK_RAM_SIZE);
      off      = lin_off % 16'(BANK_RAM_SIZE);
      target_o = TGT_FILE;
      addr_o   = ptr_i[14:0];
      if (ptr_i >= PTR_PROG_BASE) begin
         target_o = TGT_PROG; // RL5
         addr_o   = ptr_i[14:0];
      end else if (ptr_i >= PTR_EE_BASE && ptr_i <= PTR_EE_TOP) begin
         target_o = TGT_EE; // RL5
         addr_o   = {7'h00, ptr_i[7:0]};
      end else if (ptr_i >= PTR_LIN_BASE && ptr_i <= PTR_LIN_TOP) begin
         // Linear RAM folds onto the banked RAM block of each bank
         addr_o = 15'({bank[7:0], 7'h00} + {8'h00, BANK_RAM_BASE}
                      + off[14:0]); // RL7
      end
   end
endmodule
`default_nettype wire

// *** hdl/return_stack.sv ***
`timescale 1ns/100ps
`default_nettype none
module return_stack
   import flow_pkg::*;
#(
   parameter int unsigned DEPTH = STACK_DEPTH,
   parameter int unsigned WIDTH = PC_W
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   // Operations
   input  wire logic             push_i,
   input  wire logic             pop_i,
   input  wire logic [WIDTH-1:0] push_addr_i,
   // Results
   output logic      [WIDTH-1:0] top_o,
   output logic                  overflow_o,
   output logic                  underflow_o
);
   localparam int unsigned PTR_BITS = $clog2(DEPTH);

   logic [WIDTH-1:0]    mem_q [DEPTH];
   logic [WIDTH-1:0]    mem_d [DEPTH];
   logic [PTR_BITS:0]   cnt_q;
   logic [PTR_BITS:0]   cnt_d;
   logic [PTR_BITS-1:0] idx;

   always_comb begin
      mem_d       = mem_q;
      cnt_d       = cnt_q;
      overflow_o  = 1'b0;
      underflow_o = 1'b0;
      idx         = cnt_q[PTR_BITS-1:0];
      if (push_i) begin
         if (cnt_q == (PTR_BITS+1)'(DEPTH)) begin
            overflow_o = 1'b1; // RL3
         end else begin
            mem_d[idx] = push_addr_i; // RL2
            cnt_d      = cnt_q + 1'b1;
         end
      end else if (pop_i) begin
         if (cnt_q == '0) begin
            underflow_o = 1'b1; // RL3
         end else begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   // Top entry is read from flip-flops so a pop returns in the same cycle
   assign top_o = (cnt_q == '0) ? '0 : mem_q[PTR_BITS'(cnt_q - 1'b1)];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
      mem_q <= mem_d;
   end
endmodule
`default_nettype wire

// *** sim/cpu_program_flow_core_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module cpu_program_flow_core_monitor
   import flow_pkg::*;
#(
   parameter bit FLASH_16K = 1'b1
) (
   // Clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                rst_i,
   // Watched inputs
   input  wire logic                step_i,
   input  wire logic [OPC_W-1:0]    opcode_i,
   input  wire logic                call_i,
   input  wire logic                retfie_i,
   input  wire logic                irq_i,
   input  wire logic [PC_W-1:0]     jump_addr_i,
   input  wire logic [SHADOW_W-1:0] status_i,
   input  wire logic [SHADOW_W-1:0] wreg_i,
   input  wire logic                ptr_sel_i,
   input  wire logic                ptr_wr_i,
   input  wire logic                ptr_inc_i,
   input  wire logic                indirect_access_i,
   input  wire logic                stack_err_rst_en_i,
   input  wire logic                clr_overflow_i,
   input  wire logic                clr_underflow_i,
   // Watched outputs
   input  wire logic                stack_overflow_flag_o,
   input  wire logic                stack_underflow_flag_o,
   input  wire logic                soft_reset_o,
   input  wire logic [PC_W-1:0]     prog_addr_o,
   input  wire logic                prog_oob_o,
   input  wire target_e             data_target_o,
   input  wire logic                stall_o,
   input  wire logic                insn_illegal_o,
   input  wire logic                restore_o,
   input  wire logic [SHADOW_W-1:0] status_shad_o,
   input  wire logic [SHADOW_W-1:0] wreg_shad_o
);
   localparam logic [14:0] LAST = FLASH_16K ? LAST_ADDR_16K : LAST_ADDR_8K;
   logic take;
   assign take = step_i && !stall_o;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   AST_RST_VEC:
      assert property ($fell(rst_i) |-> prog_addr_o == RESET_VECTOR && !stall_o)
      else $error("pc not at reset vector");
   AST_IRQ_VEC:
      assert property (take && irq_i && !indirect_access_i
         |=> prog_addr_o == IRQ_VECTOR || stack_overflow_flag_o)
      else $error("pc not at interrupt vector");
   AST_CALL_PC:
      assert property (take && call_i && !irq_i && !indirect_access_i
         |=> prog_addr_o == $past(jump_addr_i) || stack_overflow_flag_o)
      else $error("call did not reach its target");
   AST_SHADOW:
      assert property (take && irq_i |=> status_shad_o == $past(status_i)
         && wreg_shad_o == $past(wreg_i))
      else $error("shadow copy wrong on interrupt entry");
   AST_RESTORE:
      assert property (take && retfie_i && !irq_i |=> restore_o ##1 !restore_o)
      else $error("restore pulse missing");
   AST_OVF_HOLD:
      assert property (stack_overflow_flag_o && !clr_overflow_i
         |=> stack_overflow_flag_o)
      else $error("overflow flag lost");
   AST_UNF_HOLD:
      assert property (stack_underflow_flag_o && !clr_underflow_i
         |=> stack_underflow_flag_o)
      else $error("underflow flag lost");
   AST_UNF_RST:
      assert property ($rose(stack_underflow_flag_o) && stack_err_rst_en_i
         |=> soft_reset_o ##1 !soft_reset_o)
      else $error("no reset request after underflow");
   AST_SOFT_CAUSE:
      assert property (soft_reset_o |-> $past(stack_err_rst_en_i)
         && ($past(stack_overflow_flag_o) || $past(stack_underflow_flag_o)))
      else $error("reset request without stack error");
   AST_STALL:
      assert property (take && indirect_access_i && data_target_o == TGT_PROG
         && !$past(ptr_wr_i) && !$past(ptr_inc_i) && $stable(ptr_sel_i)
         |=> stall_o ##1 !stall_o)
      else $error("program fetch stall not one cycle");
   AST_OOB:
      assert property (prog_oob_o == (prog_addr_o > LAST))
      else $error("flash bound flag wrong");
   AST_ILLEGAL:
      assert property (step_i |-> insn_illegal_o == (opcode_i >= NUM_INSNS))
      else $error("illegal code flag wrong");
endmodule

bind cpu_program_flow_core cpu_program_flow_core_monitor
   #(.FLASH_16K(FLASH_16K)) i_cpu_program_flow_core_monitor (.*);
`default_nettype wire

// *** sim/cpu_program_flow_core_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module cpu_program_flow_core_tb_top
   import flow_pkg::*;
();
   localparam logic [5:0] K_NONE = 6'h00, K_CALL = 6'h20, K_RET = 6'h10;
   localparam logic [5:0] K_RFI = 6'h08, K_IRQ = 6'h04, K_IND = 6'h02;
   localparam logic [5:0] K_INC = 6'h01;
   logic clk_sys_i, rst_i, step_i, call_i, ret_i, retfie_i, jump_i, irq_i;
   logic ptr_sel_i, ptr_wr_i, ptr_inc_i, indirect_access_i, stack_err_rst_en_i;
   logic clr_overflow_i, clr_underflow_i, stack_overflow_flag_o, stall_o;
   logic stack_underflow_flag_o, soft_reset_o, prog_oob_o, insn_illegal_o;
   logic restore_o;
   logic [OPC_W-1:0]    opcode_i;
   logic [PC_W-1:0]     jump_addr_i, prog_addr_o;
   logic [SHADOW_W-1:0] status_i, wreg_i, bsr_i, pclath_i;
   logic [SHADOW_W-1:0] status_shad_o, wreg_shad_o, bsr_shad_o, pclath_shad_o;
   logic [PTR_W-1:0]    ptr_wdata_i;
   logic [INSN_W-1:0]   prog_data_i;
   logic [14:0]         data_addr_o;
   logic [DATA_W-1:0]   indirect_prog_data_o;
   target_e             data_target_o;
   int                  n_fail = 0;
   int                  n_tests = 0;

   cpu_program_flow_core #(.FLASH_16K(1'b1)) i_cpu_program_flow_core (.*);
   prog_mem_model i_prog_mem_model (.clk_sys_i(clk_sys_i),
      .addr_i(prog_addr_o), .oob_i(prog_oob_o), .data_o(prog_data_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Each step is followed by an idle edge so no strobe is set twice at once
   task automatic do_step(input logic [5:0] k, input logic [14:0] a);
      @(posedge clk_sys_i);
      step_i <= 1'b1;
      {call_i, ret_i, retfie_i, irq_i, indirect_access_i, ptr_inc_i} <= k;
      jump_addr_i <= a;
      @(posedge clk_sys_i);
      step_i <= 1'b0;
      {call_i, ret_i, retfie_i, irq_i, indirect_access_i, ptr_inc_i} <= K_NONE;
      #1;
   endtask

   task automatic tick(input int n, input logic [1:0] clr);
      @(posedge clk_sys_i);
      {clr_overflow_i, clr_underflow_i} <= clr;
      repeat (n) @(posedge clk_sys_i);
      // With n = 0 the strobes were just set; never set them twice at once
      if (n > 0) {clr_overflow_i, clr_underflow_i} <= 2'b00;
      #1;
   endtask

   task automatic wr_ptr(input logic s, input logic [15:0] v);
      @(posedge clk_sys_i);
      ptr_sel_i <= s;
      ptr_wr_i <= 1'b1;
      ptr_wdata_i <= v;
      @(posedge clk_sys_i);
      ptr_wr_i <= 1'b0;
      tick(2, 2'b00);
   endtask

   task automatic do_reset;
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic t_reset;
      chk("pc", prog_addr_o, 16'h0000);
      chk("stall", stall_o, 16'h0000);
      chk("ovf", stack_overflow_flag_o, 16'h0000);
      chk("unf", stack_underflow_flag_o, 16'h0000);
      for (int c = 46; c < 50; c++) begin
         @(posedge clk_sys_i);
         opcode_i <= 6'(c);
         #1;
         chk("illegal", insn_illegal_o, 16'(c >= 48));
      end
      $display("test reset done");
   endtask

   task automatic t_call;
      do_step(K_CALL, 15'h1234);
      chk("pc", prog_addr_o, 16'h1234);
      do_step(K_RET, 15'h0000);
      chk("pc", prog_addr_o, 16'h0001);
      do_step(K_CALL, 15'h7FFF);
      chk("oob", prog_oob_o, 16'h0001);
      do_step(K_NONE, 15'h0000);
      chk("pc", prog_addr_o, 16'h0000);
      do_step(K_RET, 15'h0000);
      chk("pc", prog_addr_o, 16'h0002);
      chk("oob", prog_oob_o, 16'h0000);
      $display("test call done");
   endtask

   task automatic t_irq;
      @(posedge clk_sys_i);
      status_i <= 8'hA5;
      wreg_i <= 8'h3C;
      do_step(K_IRQ, 15'h0000);
      chk("pc", prog_addr_o, 16'h0004);
      chk("status", status_shad_o, 16'h00A5);
      chk("wreg", wreg_shad_o, 16'h003C);
      chk("bsr", bsr_shad_o, 16'h0011);
      chk("pclath", pclath_shad_o, 16'h0022);
      status_i <= 8'h00;
      wreg_i <= 8'h00;
      do_step(K_RFI, 15'h0000);
      chk("restore", restore_o, 16'h0001);
      chk("pc", prog_addr_o, 16'h0003);
      chk("status", status_shad_o, 16'h00A5);
      @(posedge clk_sys_i);
      jump_i <= 1'b1;
      do_step(K_NONE, 15'h3FFF);
      chk("pc", prog_addr_o, 16'h3FFF);
      chk("oob", prog_oob_o, 16'h0000);
      jump_i <= 1'b0;
      do_step(K_NONE, 15'h0000);
      chk("pc", prog_addr_o, 16'h4000);
      chk("oob", prog_oob_o, 16'h0001);
      $display("test irq done");
   endtask

   task automatic t_stack;
      do_reset;
      for (int n = 0; n < 17; n++) begin
         do_step(K_CALL, 15'h7FFE);
         chk("ovf", stack_overflow_flag_o, 16'(n == 16));
      end
      tick(0, 2'b00);
      chk("soft", soft_reset_o, 16'h0000);
      for (int n = 0; n < 17; n++) begin
         do_step(K_RET, 15'h0000);
         if (n < 16)
            chk("ret", prog_addr_o, (n < 15) ? 16'h7FFF : 16'h0001);
         chk("unf", stack_underflow_flag_o, 16'(n == 16));
      end
      do_reset;
      chk("ovf", stack_overflow_flag_o, 16'h0001);
      chk("unf", stack_underflow_flag_o, 16'h0001);
      tick(1, 2'b11);
      chk("flags", {stack_overflow_flag_o, stack_underflow_flag_o}, 16'h0);
      stack_err_rst_en_i <= 1'b1;
      do_step(K_CALL, 15'h0100);
      do_step(K_RET, 15'h0000);
      do_step(K_RET, 15'h0000);
      chk("unf", stack_underflow_flag_o, 16'h0001);
      tick(0, 2'b00);
      chk("soft", soft_reset_o, 16'h0001);
      chk("pc", prog_addr_o, 16'h0000);
      tick(0, 2'b00);
      chk("unf", stack_underflow_flag_o, 16'h0001);
      stack_err_rst_en_i <= 1'b0;
      tick(1, 2'b01);
      $display("test stack done");
   endtask

   task automatic t_ptr;
      wr_ptr(1'b0, 16'h8123);
      wr_ptr(1'b1, 16'h204F);
      chk("addr", data_addr_o, 16'h006F);
      chk("tgt", data_target_o, TGT_FILE);
      ptr_sel_i <= 1'b0;
      tick(2, 2'b00);
      chk("addr", data_addr_o, 16'h0123);
      chk("tgt", data_target_o, TGT_PROG);
      do_step(K_IND, 15'h0000);
      chk("stall", stall_o, 16'h0001);
      chk("fetch", prog_addr_o, 16'h0123);
      tick(0, 2'b00);
      chk("stall", stall_o, 16'h0000);
      chk("word", indirect_prog_data_o, 16'h00DC);
      ptr_sel_i <= 1'b1;
      do_step(K_INC, 15'h0000);
      tick(2, 2'b00);
      chk("addr", data_addr_o, 16'h00A0);
      wr_ptr(1'b1, 16'h7010);
      chk("tgt", data_target_o, TGT_EE);
      $display("test pointer done");
   endtask

   initial begin
      rst_i = 1'b1;
      {step_i, call_i, ret_i, retfie_i, jump_i, irq_i, ptr_sel_i} = '0;
      {ptr_wr_i, ptr_inc_i, indirect_access_i, stack_err_rst_en_i} = '0;
      {clr_overflow_i, clr_underflow_i} = '0;
      opcode_i = '0;
      jump_addr_i = '0;
      {status_i, wreg_i} = '0;
      bsr_i = 8'h11;
      pclath_i = 8'h22;
      ptr_wdata_i = '0;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      t_reset;
      t_call;
      t_irq;
      t_stack;
      t_ptr;
      stop_test;
   end

   // Under 150 cycles are expected; far longer means a hang
   initial begin
      #100000;
      n_fail++;
      stop_test;
   end
endmodule
`default_nettype wire

// *** sim/prog_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model
   import flow_pkg::*;
(
   // Clock
   input  wire logic              clk_sys_i,
   // Fetch port
   input  wire logic [PC_W-1:0]   addr_i,
   input  wire logic              oob_i,
   output logic      [INSN_W-1:0] data_o
);
   logic flip_q;
   // Unimplemented flash toggles so a stale word can never look right
   always_ff @(posedge clk_sys_i) flip_q <= (flip_q === 1'b1) ? 1'b0 : 1'b1;
   assign data_o = oob_i ? {INSN_W{flip_q}} : {addr_i[6:0], ~addr_i[6:0]};
endmodule
`default_nettype wire
